// *** rtl/liu_pkg.sv ***
`default_nettype none
package liu_pkg;

  // global register map
  localparam logic [5:0] ADDR_REDUNDANCY = 6'h00;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h20;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h21;
  localparam logic [5:0] ADDR_PART_NUMBER = 6'h3e;
  localparam logic [5:0] ADDR_REVISION = 6'h3f;

  // per-channel registers: channel n sits at offset + n * stride
  localparam logic [5:0] CHAN_STRIDE = 6'h08;
  localparam logic [5:0] OFS_ALARM_STATUS = 6'h03;
  localparam logic [5:0] OFS_JITTER_CTRL = 6'h07;

  // field positions
  localparam int REDUN_TX_LSB = 0;
  localparam int REDUN_RX_LSB = 4;
  localparam int ALARM_DMO_BIT = 0;
  localparam int ALARM_LOS_BIT = 1;
  localparam int ALARM_FL_BIT = 3;
  localparam int JCTRL_LOW_BIT = 0;
  localparam int JCTRL_HIGH_BIT = 1;
  localparam int JCTRL_PATH_BIT = 2;

  // reset values
  localparam logic [7:0] REDUNDANCY_RST = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [2:0] JITTER_CTRL_RST = 3'h0;

  // identification values, arbitrary
  localparam logic [7:0] PART_CODE_DEFAULT = 8'h5a;
  localparam logic [7:0] REVISION_DEFAULT = 8'h01;

  // jitter fifo sizing
  localparam int JA_DEPTH = 32;
  localparam logic [5:0] JA_LIMIT_SHORT = 6'h10;
  localparam logic [5:0] JA_LIMIT_LONG = 6'h20;
  localparam logic [5:0] JA_MARGIN = 6'h02;

  // serial frame: rw, six address bits, one pad bit, eight data bits
  localparam logic [4:0] FRAME_CMD_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  typedef enum logic [1:0] {
    DEPTH_SHORT = 2'b00,
    DEPTH_LONG = 2'b01,
    DEPTH_OFF_A = 2'b10,
    DEPTH_OFF_B = 2'b11
  } depth_code_e;

  typedef enum logic [1:0] {
    SP_IDLE = 2'b00,
    SP_CMD = 2'b01,
    SP_DATA = 2'b10
  } port_state_e;

  // fill limit for a depth code
  function automatic logic [5:0] depth_limit(input logic [1:0] code);
    return (code == DEPTH_LONG) ? JA_LIMIT_LONG : JA_LIMIT_SHORT;
  endfunction

  // attenuator in use for a depth code
  function automatic logic depth_active(input logic [1:0] code);
    return !code[1];
  endfunction

endpackage
`default_nettype wire

// *** rtl/jitter_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module jitter_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic wr_clk_in,
  input wire logic wr_rst_n_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [$clog2(DEPTH):0] wr_limit_in,
  output logic wr_ready_out,
  input wire logic rd_clk_in,
  input wire logic rd_rst_n_in,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in,
  input wire logic flush_in,
  output logic [$clog2(DEPTH):0] rd_fill_out
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_bin_ff, wr_gray_ff, rq1_ff, rq2_ff;
  logic [AW:0] rd_bin_ff, rd_gray_ff, wq1_ff, wq2_ff;
  logic [AW:0] wr_fill, flush_left_ff;
  logic wr_fire, pop, out_valid_ff;
  logic [WIDTH-1:0] out_data_ff;

  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b[AW] = g[AW];
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // write side; limit caps the fill so the short depth really fills at 16
  assign wr_fill = wr_bin_ff - gray2bin(rq2_ff);
  assign wr_ready_out = (wr_fill < wr_limit_in);
  assign wr_fire = wr_valid_in && wr_ready_out;

  always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
    if (!wr_rst_n_in) begin
      wr_bin_ff <= '0;
      wr_gray_ff <= '0;
    end else if (wr_fire) begin
      wr_bin_ff <= wr_bin_ff + 1'b1;
      wr_gray_ff <= bin2gray(wr_bin_ff + 1'b1);
    end
  end

  // storage has no reset, only pointers do
  always_ff @(posedge wr_clk_in) begin
    if (wr_fire) begin
      mem_ff[wr_bin_ff[AW-1:0]] <= wr_data_in;
    end
  end

  // read pointer into the write domain
  always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
    if (!wr_rst_n_in) begin
      rq1_ff <= '0;
      rq2_ff <= '0;
    end else begin
      rq1_ff <= rd_gray_ff;
      rq2_ff <= rq1_ff;
    end
  end

  // write pointer into the read domain
  always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
    if (!rd_rst_n_in) begin
      wq1_ff <= '0;
      wq2_ff <= '0;
    end else begin
      wq1_ff <= wr_gray_ff;
      wq2_ff <= wq1_ff;
    end
  end

  assign rd_fill_out = gray2bin(wq2_ff) - rd_bin_ff;
  assign pop = (rd_fill_out != '0) && !flush_in && ((flush_left_ff != '0) || !out_valid_ff || rd_ready_in);

  // flush drains one word a cycle so the gray pointer never jumps
  always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
    if (!rd_rst_n_in) begin
      rd_bin_ff <= '0;
      rd_gray_ff <= '0;
      flush_left_ff <= '0;
      out_valid_ff <= 1'b0;
      out_data_ff <= '0;
    end else begin
      if (pop) begin
        rd_bin_ff <= rd_bin_ff + 1'b1;
        rd_gray_ff <= bin2gray(rd_bin_ff + 1'b1);
      end
      if (flush_in) begin
        flush_left_ff <= rd_fill_out;
        out_valid_ff <= 1'b0;
      end else if (flush_left_ff != '0) begin
        if (pop) begin
          flush_left_ff <= flush_left_ff - 1'b1;
        end
      end else if (pop) begin
        out_valid_ff <= 1'b1;
        out_data_ff <= mem_ff[rd_bin_ff[AW-1:0]];
      end else if (rd_ready_in) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  assign rd_valid_out = out_valid_ff;
  assign rd_data_out = out_data_ff;
endmodule // jitter_fifo
`default_nettype wire

// *** rtl/liu_host_control_jitter_fifo.sv ***
// Operation
// [RQ1] host mode: per-channel bit picks attenuator path
// [RQ2] hardware mode: one pin picks all paths
// [RQ3] fifo depth selectable, 16 or 32
// [RQ4] host mode: two-bit field sets depth/off
// [RQ5] hardware mode: two pins set depth/off
// [RQ6] write on path clock, read dejittered
// [RQ7] alarm when within two of limits
// [RQ8] alarm read clears fifo and alarm
// [RQ9] software prefers 16 for delay-sensitive use
// [RQ10] config pin high selects host mode
// [RQ11] five-wire serial port, host drives clock
// [RQ12] active-low interrupt reports channel alarms
// [RQ13] host mode ignores hardware config pins
// [RQ14] shared pins: serial port or config
// [RQ15] host mode: driver pin gated by bit
// [RQ16] read-only part and revision registers
// [RQ17] status bit set when channel needs service
// [RQ18] enable bit gates each channel interrupt
// [RQ19] interrupt held while status and enable
`timescale 1ns/1ps
`default_nettype none
module liu_host_control_jitter_fifo #(
  parameter logic [7:0] PART_CODE = liu_pkg::PART_CODE_DEFAULT,
  parameter logic [7:0] REVISION_CODE = liu_pkg::REVISION_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  input wire logic line_clk_in,
  input wire logic config_source_pin_in,
  input wire logic cs_n_pin_in,
  input wire logic sclk_pin_in,
  input wire logic serial_in_pin_in,
  input wire logic serial_out_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_out,
  input wire logic irq_n_pin_in,
  output logic irq_n_pin_out,
  output logic irq_n_pin_oe_out,
  input wire logic atten_path_select_pin_in,
  input wire logic depth_sel_low_pin_in,
  input wire logic depth_sel_high_pin_in,
  input wire logic line_driver_on_pin_in,
  input wire logic [1:0] signal_absent_in,
  input wire logic [1:0] driver_monitor_alarm_in,
  input wire logic [1:0] rx_data_in,
  input wire logic [1:0] rx_valid_in,
  output logic [1:0] rx_ready_out,
  input wire logic [1:0] tx_data_in,
  input wire logic [1:0] tx_valid_in,
  output logic [1:0] tx_ready_out,
  output logic [1:0] dejit_data_out,
  output logic [1:0] dejit_valid_out,
  input wire logic [1:0] dejit_ready_in,
  output logic [1:0] atten_active_out,
  output logic [1:0] atten_in_tx_path_out,
  output logic [1:0] line_driver_en_out,
  output logic [1:0] receiver_on_out,
  output logic host_mode_out,
  output logic hw_rx_clk_inv_out,
  output logic hw_tx_clk_inv_out,
  output logic hw_rx_monitor_out,
  output logic hw_los_mute_out
);
  localparam int PIN_CFG = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SDI = 3;
  localparam int PIN_SDO = 4;
  localparam int PIN_IRQ = 5;
  localparam int PIN_PATH = 6;
  localparam int PIN_DLO = 7;
  localparam int PIN_DHI = 8;
  localparam int PIN_LINE_DRIVER_ON = 9;

  logic [1:0] rst_ff, lk_rst_ff;
  logic rst_n, lk_rst_n;
  logic [9:0] pin_s1_ff, pin_s2_ff, pin_raw;
  logic host_mode_ff, sclk_prev_ff, sclk_rise, cs_active;
  liu_pkg::port_state_e state_ff;
  logic [4:0] bit_cnt_ff;
  logic [7:0] shift_in_ff, nxt_shift, out_shift_ff, rd_data;
  logic is_read_ff, cmd_done, rd_strobe, wr_strobe;
  logic [5:0] rd_addr, addr_hold_ff;
  logic [7:0] redundancy_ff, irq_en_ff;
  logic [2:0] jctrl_ff [2];
  logic [2:0] cfg_sys_ff [2];
  logic [1:0] fl_ff, alarm_set, alarm_clear, irq_pending;
  logic irq_n_ff;

  // channel register hit test, shared by read and write decode
  function automatic logic chan_hit(input logic [5:0] addr, input logic [5:0] ofs, input int ch);
    return addr == 6'(ofs + CHAN_STRIDE_MUL(ch));
  endfunction

  function automatic logic [5:0] CHAN_STRIDE_MUL(input int ch);
    return (ch == 0) ? 6'h00 : liu_pkg::CHAN_STRIDE;
  endfunction

  // reset release through two flops in each domain
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  always_ff @(posedge line_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lk_rst_ff <= 2'h0;
    end else begin
      lk_rst_ff <= {lk_rst_ff[0], 1'b1};
    end
  end
  assign lk_rst_n = lk_rst_ff[1];

  // every pin passes two flops; only the second stage is read
  assign pin_raw = {line_driver_on_pin_in, depth_sel_high_pin_in, depth_sel_low_pin_in, atten_path_select_pin_in,
                    irq_n_pin_in, serial_out_pin_in, serial_in_pin_in, sclk_pin_in, cs_n_pin_in, config_source_pin_in};
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_ff <= 10'h000;
      pin_s2_ff <= 10'h000;
      host_mode_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff <= pin_raw;
      pin_s2_ff <= pin_s1_ff;
      host_mode_ff <= pin_s2_ff[PIN_CFG]; // RQ10
      sclk_prev_ff <= pin_s2_ff[PIN_SCLK];
    end
  end

  // serial port is only alive in host mode; sclk is oversampled, not a clock
  assign sclk_rise = pin_s2_ff[PIN_SCLK] && !sclk_prev_ff;
  assign cs_active = host_mode_ff && !pin_s2_ff[PIN_CS]; // RQ11
  assign nxt_shift = {shift_in_ff[6:0], pin_s2_ff[PIN_SDI]};
  assign cmd_done = sclk_rise && (state_ff == liu_pkg::SP_CMD) && (bit_cnt_ff == liu_pkg::FRAME_CMD_BITS - 5'h01);
  assign rd_strobe = cmd_done && nxt_shift[7];
  assign rd_addr = nxt_shift[6:1];
  assign wr_strobe = sclk_rise && (state_ff == liu_pkg::SP_DATA) && !is_read_ff &&
                     (bit_cnt_ff == liu_pkg::FRAME_BITS - 5'h01);

  // frame sequencer: command byte then data byte, msb first
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= liu_pkg::SP_IDLE;
      bit_cnt_ff <= 5'h00;
      shift_in_ff <= 8'h00;
      is_read_ff <= 1'b0;
      out_shift_ff <= 8'h00;
    end else if (!cs_active) begin
      state_ff <= liu_pkg::SP_IDLE;
      bit_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        liu_pkg::SP_IDLE: begin
          state_ff <= liu_pkg::SP_CMD;
        end
        liu_pkg::SP_CMD: begin
          if (sclk_rise) begin
            shift_in_ff <= nxt_shift;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
          end
          if (cmd_done) begin
            state_ff <= liu_pkg::SP_DATA;
            is_read_ff <= nxt_shift[7];
            out_shift_ff <= rd_data;
          end
        end
        liu_pkg::SP_DATA: begin
          if (sclk_rise) begin
            // shift after the host has sampled on this rising edge
            shift_in_ff <= nxt_shift;
            out_shift_ff <= {out_shift_ff[6:0], 1'b0};
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
            if (bit_cnt_ff == liu_pkg::FRAME_BITS - 5'h01) begin
              state_ff <= liu_pkg::SP_CMD;
              bit_cnt_ff <= 5'h00;
            end
          end
        end
        default: begin
          state_ff <= liu_pkg::SP_IDLE;
        end
      endcase
    end
  end

  // read data mux; unmapped and reserved bits read zero
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      liu_pkg::ADDR_REDUNDANCY: rd_data = redundancy_ff;
      liu_pkg::ADDR_IRQ_ENABLE: rd_data = irq_en_ff;
      liu_pkg::ADDR_IRQ_STATUS: rd_data = {6'h00, irq_pending}; // RQ17
      liu_pkg::ADDR_PART_NUMBER: rd_data = PART_CODE; // RQ16
      liu_pkg::ADDR_REVISION: rd_data = REVISION_CODE; // RQ16
      default: rd_data = 8'h00;
    endcase
    for (int ch = 0; ch < 2; ch++) begin
      if (chan_hit(rd_addr, liu_pkg::OFS_ALARM_STATUS, ch)) begin
        rd_data[liu_pkg::ALARM_FL_BIT] = fl_ff[ch];
        rd_data[liu_pkg::ALARM_LOS_BIT] = signal_absent_in[ch];
        rd_data[liu_pkg::ALARM_DMO_BIT] = driver_monitor_alarm_in[ch];
      end
      if (chan_hit(rd_addr, liu_pkg::OFS_JITTER_CTRL, ch)) begin
        rd_data = {5'h00, jctrl_ff[ch]};
      end
    end
  end

  // writable registers; read-only addresses ignore writes
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      redundancy_ff <= liu_pkg::REDUNDANCY_RST;
      irq_en_ff <= liu_pkg::IRQ_ENABLE_RST;
      jctrl_ff[0] <= liu_pkg::JITTER_CTRL_RST;
      jctrl_ff[1] <= liu_pkg::JITTER_CTRL_RST;
    end else if (wr_strobe) begin
      if (addr_hold_ff == liu_pkg::ADDR_REDUNDANCY) begin
        redundancy_ff <= nxt_shift & 8'h33;
      end
      if (addr_hold_ff == liu_pkg::ADDR_IRQ_ENABLE) begin
        irq_en_ff <= nxt_shift & 8'h03;
      end
      for (int ch = 0; ch < 2; ch++) begin
        if (chan_hit(addr_hold_ff, liu_pkg::OFS_JITTER_CTRL, ch)) begin
          jctrl_ff[ch] <= nxt_shift[2:0];
        end
      end
    end
  end

  // write address kept from the command byte; the data bits push it out of the shifter
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold_ff <= 6'h00;
    end else if (cmd_done) begin
      addr_hold_ff <= rd_addr;
    end
  end

  // effective configuration; host mode ignores the hardware config pins, but the line driver pin still gates the driver
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_sys_ff[0] <= 3'h0;
      cfg_sys_ff[1] <= 3'h0;
      line_driver_en_out <= 2'h0;
      receiver_on_out <= 2'h0;
      hw_rx_clk_inv_out <= 1'b0;
      hw_tx_clk_inv_out <= 1'b0;
      hw_rx_monitor_out <= 1'b0;
      hw_los_mute_out <= 1'b0;
    end else begin
      for (int ch = 0; ch < 2; ch++) begin
        if (host_mode_ff) begin
          cfg_sys_ff[ch] <= jctrl_ff[ch]; // RQ1 RQ4 RQ13
          line_driver_en_out[ch] <= redundancy_ff[liu_pkg::REDUN_TX_LSB + ch] & pin_s2_ff[PIN_LINE_DRIVER_ON]; // RQ15
          receiver_on_out[ch] <= redundancy_ff[liu_pkg::REDUN_RX_LSB + ch];
        end else begin
          cfg_sys_ff[ch] <= {pin_s2_ff[PIN_PATH], pin_s2_ff[PIN_DHI], pin_s2_ff[PIN_DLO]}; // RQ2 RQ5
          line_driver_en_out[ch] <= pin_s2_ff[PIN_LINE_DRIVER_ON];
          receiver_on_out[ch] <= pin_s2_ff[PIN_SDI];
        end
      end
      // shared pins act as static configuration only in hardware mode
      hw_rx_clk_inv_out <= !host_mode_ff && pin_s2_ff[PIN_CS]; // RQ14
      hw_tx_clk_inv_out <= !host_mode_ff && pin_s2_ff[PIN_SCLK];
      hw_rx_monitor_out <= !host_mode_ff && pin_s2_ff[PIN_SDO];
      hw_los_mute_out <= !host_mode_ff && pin_s2_ff[PIN_IRQ];
    end
  end

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [2:0] lk_cfg1_ff, lk_cfg2_ff;
      logic lk_active, lk_wr_valid, lk_wr_ready, lk_wr_data;
      logic [5:0] fill, limit;
      logic active, drain_ff;

      // stale fill while a flush drains is no new limit event; a link that never pauses holds this up
      always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
          drain_ff <= 1'b0;
        end else if (alarm_clear[ch]) begin
          drain_ff <= 1'b1;
        end else if (fill == 6'h00) begin
          drain_ff <= 1'b0;
        end
      end

      // configuration into the link domain; it is quasi-static
      always_ff @(posedge line_clk_in or negedge lk_rst_n) begin
        if (!lk_rst_n) begin
          lk_cfg1_ff <= 3'h0;
          lk_cfg2_ff <= 3'h0;
        end else begin
          lk_cfg1_ff <= cfg_sys_ff[ch];
          lk_cfg2_ff <= lk_cfg1_ff;
        end
      end

      // path mux on the write side; disabled attenuator accepts and drops
      assign lk_active = liu_pkg::depth_active(lk_cfg2_ff[1:0]);
      assign lk_wr_data = lk_cfg2_ff[liu_pkg::JCTRL_PATH_BIT] ? tx_data_in[ch] : rx_data_in[ch]; // RQ6
      assign lk_wr_valid = lk_active &&
                           (lk_cfg2_ff[liu_pkg::JCTRL_PATH_BIT] ? tx_valid_in[ch] : rx_valid_in[ch]);
      assign tx_ready_out[ch] = lk_cfg2_ff[liu_pkg::JCTRL_PATH_BIT] && (!lk_active || lk_wr_ready);
      assign rx_ready_out[ch] = !lk_cfg2_ff[liu_pkg::JCTRL_PATH_BIT] && (!lk_active || lk_wr_ready);

      assign active = liu_pkg::depth_active(cfg_sys_ff[ch][1:0]);
      assign limit = liu_pkg::depth_limit(cfg_sys_ff[ch][1:0]); // RQ3
      assign alarm_set[ch] = active && !drain_ff && !alarm_clear[ch] && ((fill >= limit - liu_pkg::JA_MARGIN) ||
                             ((fill <= liu_pkg::JA_MARGIN) && dejit_ready_in[ch])); // RQ7
      assign alarm_clear[ch] = rd_strobe && chan_hit(rd_addr, liu_pkg::OFS_ALARM_STATUS, ch); // RQ8

      jitter_fifo #(
        .WIDTH(1),
        .DEPTH(liu_pkg::JA_DEPTH)
      ) u_fifo (
        .wr_clk_in(line_clk_in),
        .wr_rst_n_in(lk_rst_n),
        .wr_valid_in(lk_wr_valid),
        .wr_data_in(lk_wr_data),
        .wr_limit_in(liu_pkg::depth_limit(lk_cfg2_ff[1:0])),
        .wr_ready_out(lk_wr_ready),
        .rd_clk_in(clk_sys_in),
        .rd_rst_n_in(rst_n),
        .rd_valid_out(dejit_valid_out[ch]),
        .rd_data_out(dejit_data_out[ch]),
        .rd_ready_in(dejit_ready_in[ch]),
        .flush_in(alarm_clear[ch] || !active), // RQ8
        .rd_fill_out(fill)
      );
      assign atten_active_out[ch] = active;
      assign atten_in_tx_path_out[ch] = cfg_sys_ff[ch][liu_pkg::JCTRL_PATH_BIT];
    end
  endgenerate

  // margin alarm: the clear wins over a new event in the clearing cycle
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      fl_ff <= 2'h0;
    end else begin
      fl_ff <= alarm_set | (fl_ff & ~alarm_clear); // RQ7 RQ8
    end
  end

  // channel needs service while any of its sources is up
  assign irq_pending = fl_ff | signal_absent_in | driver_monitor_alarm_in; // RQ17

  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_n_ff <= 1'b1;
    end else begin
      irq_n_ff <= !(|(irq_pending & irq_en_ff[1:0])); // RQ18 RQ19
    end
  end

  // pins 27/28 are outputs only in host mode
  assign irq_n_pin_out = irq_n_ff; // RQ12
  assign irq_n_pin_oe_out = host_mode_ff;
  assign serial_out_pin_out = out_shift_ff[7];
  assign serial_out_pin_oe_out = cs_active && (state_ff == liu_pkg::SP_DATA) && is_read_ff; // RQ14
  assign host_mode_out = host_mode_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n);

  a_irq_follows_src: assert property (|(irq_pending & irq_en_ff[1:0]) |=> !irq_n_pin_out) // RQ19
    else $error("interrupt not asserted for enabled pending channel");
  a_irq_masked_off: assert property (!(|(irq_pending & irq_en_ff[1:0])) |=> irq_n_pin_out) // RQ18
    else $error("interrupt asserted with nothing enabled");
  a_alarm_sets: assert property (alarm_set[0] |=> fl_ff[0] && irq_pending[0]) // RQ7
    else $error("margin alarm not raised");
  a_alarm_read_clear: assert property (alarm_clear[0] && !alarm_set[0] |=> !fl_ff[0]) // RQ8
    else $error("margin alarm survived its read");
  a_host_path_bit: assert property (host_mode_ff && jctrl_ff[0][liu_pkg::JCTRL_PATH_BIT]
    |=> atten_in_tx_path_out[0]) // RQ1
    else $error("host path bit not applied");
  a_hw_path_pin: assert property (!host_mode_ff && pin_s2_ff[PIN_PATH] |=> &atten_in_tx_path_out) // RQ2
    else $error("hardware path pin not applied to all channels");
  a_depth_off: assert property (!host_mode_ff && pin_s2_ff[PIN_DHI] |=> atten_active_out == 2'h0) // RQ5
    else $error("attenuator active while disabled by pins");
  a_driver_gate: assert property (host_mode_ff && !redundancy_ff[liu_pkg::REDUN_TX_LSB]
    |=> !line_driver_en_out[0]) // RQ15
    else $error("line driver on while its bit is clear");
  a_part_read: assert property (cmd_done && nxt_shift[7] && rd_addr == liu_pkg::ADDR_PART_NUMBER
    |=> out_shift_ff == PART_CODE ##1 serial_out_pin_out == PART_CODE[7]) // RQ16
    else $error("part number not loaded for read");
  a_shared_pins_hw: assert property (!host_mode_ff |-> !serial_out_pin_oe_out && !irq_n_pin_oe_out) // RQ14
    else $error("shared pin driven in hardware mode");
endmodule // liu_host_control_jitter_fifo
`default_nettype wire

// *** testbench/host_port_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial host processor: frames msb first, each sclk phase five system cycles
module host_port_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out,
  output logic done_out,
  output logic [7:0] rdata_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
    done_out = 1'b0;
    rdata_out = 8'h00;
  end

  // rw, six address bits, pad, data; sdo sampled as sclk rises
  task automatic frame(input logic rw, input logic [5:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, 1'b0, d};
    @(negedge clk_in) cs_n_out = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi_out = f[i];
      repeat (5) @(negedge clk_in);
      sclk_out = 1'b1;
      if (i < 8) rdata_out[i] = sdo_in;
      repeat (5) @(negedge clk_in);
      sclk_out = 1'b0;
    end
    repeat (5) @(negedge clk_in);
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out; // released line never keeps its last bit
    done_out = rw;
    @(negedge clk_in) done_out = 1'b0;
  endtask
endmodule // host_port_model
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_in, arst_n_in, line_clk_in, config_source_pin_in, cs_n_pin_in, sclk_pin_in, serial_in_pin_in;
  logic serial_out_pin_in, serial_out_pin_out, serial_out_pin_oe_out, irq_n_pin_in, irq_n_pin_out, irq_n_pin_oe_out;
  logic atten_path_select_pin_in, depth_sel_low_pin_in, depth_sel_high_pin_in, line_driver_on_pin_in, host_mode_out;
  logic hw_rx_clk_inv_out, hw_tx_clk_inv_out, hw_rx_monitor_out, hw_los_mute_out, host_done;
  logic [1:0] signal_absent_in, driver_monitor_alarm_in, rx_data_in, rx_valid_in, rx_ready_out, tx_data_in;
  logic [1:0] tx_valid_in, tx_ready_out, dejit_data_out, dejit_valid_out, dejit_ready_in, atten_active_out;
  logic [1:0] atten_in_tx_path_out, line_driver_en_out, receiver_on_out;
  logic [7:0] host_rdata;
  logic [7:0] exp_q[$];
  logic dq[$];
  logic [31:0] seed = 32'h0001_54ef;
  int err_total = 0;
  int n_compared = 0;
  int n_acc = 0;

  liu_host_control_jitter_fifo dut (.*);
  host_port_model host (.clk_in(clk_sys_in), .sdo_in(serial_out_pin_in), .cs_n_out(cs_n_pin_in),
    .sclk_out(sclk_pin_in), .sdi_out(serial_in_pin_in), .done_out(host_done), .rdata_out(host_rdata));

  // pins resolve with board pull-ups when nobody drives them
  assign serial_out_pin_in = serial_out_pin_oe_out ? serial_out_pin_out : 1'b1;
  assign irq_n_pin_in = irq_n_pin_oe_out ? irq_n_pin_out : 1'b1;
  always #12.5 clk_sys_in = ~clk_sys_in;
  always #6 line_clk_in = ~line_clk_in;

  function automatic logic rnd_bit();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[0];
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.frame(1'b1, a, 8'h00);
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.frame(1'b0, a, d);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // read answers and dejittered bits are matched against the oldest note
  always @(posedge host_done) check("register", host_rdata, exp_q.pop_front());
  always @(posedge clk_sys_in) if (dejit_valid_out[0] && dejit_ready_in[0] && dq.size() > 0)
    check("dejit", 8'(dejit_data_out[0]), 8'(dq.pop_front()));

  // fill until refused, then three words out in order with the reader stalled first
  task automatic push_words(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge line_clk_in);
      rx_valid_in[0] = 1'b1;
      rx_data_in[0] = rnd_bit();
      if (n < 8) dq.push_back(rx_data_in[0]);
      #1 n_acc += int'(rx_ready_out[0]); // ready only moves on the taking edge
      @(posedge line_clk_in);
    end
    @(negedge line_clk_in) rx_valid_in[0] = 1'b0;
  endtask

  initial begin
    {clk_sys_in, line_clk_in, arst_n_in, depth_sel_low_pin_in, line_driver_on_pin_in} = 5'h00;
    {config_source_pin_in, atten_path_select_pin_in, depth_sel_high_pin_in} = 3'h7; // hw pins must be ignored
    {signal_absent_in, driver_monitor_alarm_in, rx_data_in, rx_valid_in, tx_data_in, tx_valid_in} = 12'h000;
    dejit_ready_in = 2'h0;
    repeat (10) @(negedge clk_sys_in);
    arst_n_in = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check("irq", 8'(irq_n_pin_out), 8'h01);
    check("mode", 8'(host_mode_out), 8'h01);
    check("tx path", 8'(atten_in_tx_path_out), 8'h00);
    rd(liu_pkg::ADDR_PART_NUMBER, liu_pkg::PART_CODE_DEFAULT);
    wr(liu_pkg::ADDR_REVISION, 8'h77);
    rd(liu_pkg::ADDR_REVISION, liu_pkg::REVISION_DEFAULT);
    line_driver_on_pin_in = 1'b1;
    wr(liu_pkg::ADDR_REDUNDANCY, 8'h11);
    rd(liu_pkg::ADDR_REDUNDANCY, 8'h11);
    check("driver", 8'(line_driver_en_out), 8'h01);
    check("receiver", 8'(receiver_on_out), 8'h01);
    wr(6'h0f, 8'h05);
    check("tx path", 8'(atten_in_tx_path_out), 8'h02);
    wr(6'h0f, 8'h02);
    check("active", 8'(atten_active_out), 8'h01);
    signal_absent_in = 2'h2;
    wr(liu_pkg::ADDR_IRQ_ENABLE, 8'h01);
    rd(liu_pkg::ADDR_IRQ_STATUS, 8'h02);
    check("irq", 8'(irq_n_pin_out), 8'h01);
    wr(liu_pkg::ADDR_IRQ_ENABLE, 8'h02);
    check("irq", 8'(irq_n_pin_out), 8'h00);
    signal_absent_in = 2'h0;
    repeat (6) @(negedge clk_sys_in);
    check("irq", 8'(irq_n_pin_out), 8'h01);
    push_words(40);
    // sixteen in the fifo plus the one already in the output stage
    check("accepted", 8'(n_acc), 8'h11);
    rd(6'h03, 8'h08);
    check("flushed", 8'(dejit_valid_out[0]), 8'h00);
    rd(6'h03, 8'h00);
    push_words(3);
    @(negedge clk_sys_in) dejit_ready_in[0] = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    check("drained", 8'(dq.size()), 8'h00);
    {config_source_pin_in, depth_sel_high_pin_in, depth_sel_low_pin_in} = 3'h1;
    repeat (8) @(negedge clk_sys_in);
    check("mode", 8'(host_mode_out), 8'h00);
    check("tx path", 8'(atten_in_tx_path_out), 8'h03);
    check("active", 8'(atten_active_out), 8'h03);
    check("rx clk inv", 8'(hw_rx_clk_inv_out), 8'h01);
    check("tx clk inv", 8'(hw_tx_clk_inv_out), 8'h00);
    tally_and_finish();
  end

  // about 2100 cycles expected, so 200 us means a hang
  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
